/* File: include/lfm_params.svh */
// timing, level and channel constants for the led channel fault manager
`ifndef LFM_PARAMS_SVH
`define LFM_PARAMS_SVH
// ****************************************
// channel and timing constants
// ****************************************
`define LFM_NUM_CH           6
`define LFM_TIMEOUT_PWM      3'h6
`define LFM_CLK_MHZ          125
`define LFM_SHORT_MS         31
`define LFM_FAST_TIMEOUT_US  800
// ****************************************
// current scale codes (percent of setting)
// ****************************************
`define LFM_SCALE_FULL       7'h64
`define LFM_SCALE_STEP1      7'h4c
`define LFM_SCALE_STEP2      7'h32
`define LFM_SCALE_STEP3      7'h19
`endif

/* File: include/lfm_pkg.sv */
// types shared by the led channel fault manager
package lfm_pkg;
  // ****************************************
  // supervisor states
  // ****************************************
  typedef enum logic [3:0] {
    LFM_IDLE   = 4'b0001,
    LFM_RUN    = 4'b0010,
    LFM_COOL   = 4'b0100,
    LFM_LOCKED = 4'b1000
  } lfm_state_e;
endpackage

/* File: include/lfm_ch_if.sv */
// per-channel fault signals between supervisor and channel timers
`timescale 1ns/10ps
interface lfm_ch_if;
  logic pwm_tick;
  logic fast_tick;
  logic clear;
  logic hold;
  logic fast;
  logic sink_high;
  logic below_target;
  logic force_open;
  logic disabled;
  modport sup (output pwm_tick, fast_tick, clear, hold, fast, sink_high, below_target,
               force_open, input disabled);
  modport chan (input pwm_tick, fast_tick, clear, hold, fast, sink_high, below_target,
                force_open, output disabled);
endinterface

/* File: src/lfm_channel.sv */
// fault time-out and latch for one led sink channel
`timescale 1ns/10ps
`include "lfm_params.svh"
module lfm_channel
  import lfm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // supervisor side
  lfm_ch_if.chan   ch
);
  logic       good_q, good_d;
  logic       dis_q, dis_d;
  logic [2:0] cnt_q, cnt_d;
  logic       open_now;
  logic       tick;

  // ****************************************
  // good tracking, time-out and latch
  // ****************************************
  always_comb begin
    good_d   = good_q;
    cnt_d    = cnt_q;
    dis_d    = dis_q;
    open_now = (good_q && ch.below_target) || (ch.force_open && ch.below_target); // R12
    tick     = ch.sink_high ? ch.pwm_tick : (ch.fast ? ch.fast_tick : ch.pwm_tick); // R3 R13
    if (ch.clear) begin
      good_d = 1'b0;
      cnt_d  = 3'h0;
      dis_d  = 1'b0; // R15
    end else if (!dis_q && !ch.hold) begin
      if (!ch.below_target) begin
        good_d = 1'b1; // R12
      end
      if (ch.sink_high || open_now) begin
        if (tick) begin
          if (cnt_q == `LFM_TIMEOUT_PWM - 3'h1) begin
            dis_d = 1'b1; // R3 R4 R6 R9
          end else begin
            cnt_d = cnt_q + 3'h1;
          end
        end
      end else begin
        cnt_d = 3'h0; // R1 R5
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      good_q <= 1'b0;
      cnt_q  <= 3'h0;
      dis_q  <= 1'b0;
    end else begin
      good_q <= good_d;
      cnt_q  <= cnt_d;
      dis_q  <= dis_d;
    end
  end

  assign ch.disabled = dis_q;
endmodule // lfm_channel

/* File: src/lfm_fault_manager.sv */
// fault supervisor for a six-string led sink driver with boost
// Contract
// R1: a shorted channel whose sink voltage stays below 7.5V with no upper trip stays enabled.
// R2: an upper trip turns all channels off until cool, then restarts at 76% and lower each time; the code stays at 25% from the third trip on.
// R3: without an upper trip a channel above 7.5V is disabled after six pwm time-outs.
// R4: an open string drives the output to its limit and is switched off after six time-outs.
// R5: a zener-bypassed open string below 7.5V stays enabled and sets the boost level.
// R6: another channel pushed above 7.5V by a zener-bypassed string goes off after six cycles.
// R7: with the lower trip active, every channel below target current is treated as faulty.
// R8: an upper trip from forward-voltage mismatch also stops boost switching until cooled.
// R9: above the overvoltage threshold every channel below target times out after six cycles.
// R10: a grounded output or switch node shuts the device down for good 31 ms after power-up.
// R11: the overvoltage-sense node falling below 20% of threshold counts as an output short.
// R12: a channel is good once at target; falling below target later starts its time-out.
// R13: above the lower trip the open-channel time-out is shortened.
// R14: trip shutdowns and reduced restarts keep the device active unless the enable drops.
// R15: a channel disabled by time-out stays disabled and latched until reset or re-enable.
`timescale 1ns/10ps
`include "lfm_params.svh"
module lfm_fault_manager
  import lfm_pkg::*;
#(
  parameter int NUM_CH        = `LFM_NUM_CH,
  parameter int SHORT_CYCLES  = `LFM_SHORT_MS * 1000 * `LFM_CLK_MHZ,
  parameter int FAST_CYCLES   = `LFM_FAST_TIMEOUT_US * `LFM_CLK_MHZ / `LFM_TIMEOUT_PWM
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // enable and dimming
  input  wire logic              enable,
  input  wire logic              pwm_cycle,
  // per-channel comparators
  input  wire logic [NUM_CH-1:0] sink_above_limit,
  input  wire logic [NUM_CH-1:0] below_target,
  // die temperature flags
  input  wire logic              temp_lower_trip,
  input  wire logic              temp_upper_trip,
  input  wire logic              temp_cooled,
  // boost monitors
  input  wire logic              output_overvoltage_limit,
  input  wire logic              ovp_node_low,
  input  wire logic              boost_switch_node_short,
  // channel and boost control
  output logic [NUM_CH-1:0]      led_sink_channel_en,
  output logic [NUM_CH-1:0]      channel_fault,
  output logic                   boost_run,
  output logic [6:0]             current_scale,
  output logic                   thermal_shutdown,
  output logic                   short_shutdown,
  output logic                   active
);
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NS = 2 * NUM_CH + 7;
  logic [NS-1:0] s1_q, s2_q;
  logic [NS-1:0] raw;
  assign raw = {sink_above_limit, below_target, enable, pwm_cycle, temp_lower_trip,
                temp_upper_trip, temp_cooled, output_overvoltage_limit,
                ovp_node_low | boost_switch_node_short};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic [NUM_CH-1:0] sink_s, below_s;
  logic              en_s, pwm_s, tlo_s, thi_s, tcool_s, ovl_s, short_s;
  assign {sink_s, below_s, en_s, pwm_s, tlo_s, thi_s, tcool_s, ovl_s, short_s} = s2_q;

  // ****************************************
  // pwm edge and fast time-out divider
  // ****************************************
  logic        pwm_prev_q, pwm_prev_d;
  logic [31:0] fdiv_q, fdiv_d;
  logic        pwm_tick, fast_tick;
  always_comb begin
    pwm_prev_d = pwm_s;
    pwm_tick   = pwm_s && !pwm_prev_q;
    fast_tick  = (fdiv_q == 32'(FAST_CYCLES - 1));
    fdiv_d     = (fast_tick || !tlo_s) ? 32'h0000_0000 : fdiv_q + 32'h0000_0001; // R13
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_prev_q <= 1'b0;
      fdiv_q     <= 32'h0000_0000;
    end else begin
      pwm_prev_q <= pwm_prev_d;
      fdiv_q     <= fdiv_d;
    end
  end

  // ****************************************
  // supervisor state machine
  // ****************************************
  lfm_state_e  st_q, st_d;
  logic [1:0]  step_q, step_d;
  logic [31:0] up_q, up_d;
  logic        armed_q, armed_d;
  logic        clear_ch;
  always_comb begin
    st_d     = st_q;
    step_d   = step_q;
    up_d     = up_q;
    armed_d  = armed_q;
    clear_ch = 1'b0;
    if (up_q != 32'(SHORT_CYCLES)) begin
      up_d = up_q + 32'h0000_0001;
    end
    if (up_q == 32'(SHORT_CYCLES)) begin
      armed_d = 1'b1;
    end
    case (st_q)
      LFM_IDLE: begin
        clear_ch = 1'b1; // R15
        step_d   = 2'h0;
        if (en_s) begin
          st_d = LFM_RUN;
        end
      end
      LFM_RUN: begin
        if (short_s && armed_q) begin
          st_d = LFM_LOCKED; // R10 R11
        end else if (!en_s) begin
          st_d = LFM_IDLE; // R14
        end else if (thi_s) begin
          st_d = LFM_COOL; // R2 R8
          if (step_q != 2'h3) begin
            step_d = step_q + 2'h1; // R2
          end
        end
      end
      LFM_COOL: begin
        if (short_s && armed_q) begin
          st_d = LFM_LOCKED; // R10
        end else if (!en_s) begin
          st_d = LFM_IDLE; // R14
        end else if (tcool_s && !thi_s) begin
          st_d = LFM_RUN; // R2
        end
      end
      LFM_LOCKED: begin
        st_d = LFM_LOCKED; // R10
      end
      default: begin
        st_d = LFM_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= LFM_IDLE;
      step_q  <= 2'h0;
      up_q    <= 32'h0000_0000;
      armed_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      step_q  <= step_d;
      up_q    <= up_d;
      armed_q <= armed_d;
    end
  end

  // ****************************************
  // channel timers
  // ****************************************
  logic [NUM_CH-1:0] dis;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      lfm_ch_if chi ();
      assign chi.pwm_tick     = pwm_tick;
      assign chi.fast_tick    = fast_tick;
      assign chi.clear        = clear_ch;
      assign chi.hold         = (st_q != LFM_RUN);
      assign chi.fast         = tlo_s; // R13
      assign chi.sink_high    = sink_s[gi] && !thi_s; // R3 R6
      assign chi.below_target = below_s[gi];
      assign chi.force_open   = ovl_s || tlo_s; // R7 R9 R4
      assign dis[gi]          = chi.disabled;
      lfm_channel u_ch (
        .clk  (clk),
        .rstn (rstn),
        .ch   (chi.chan)
      );
    end
  endgenerate

  // ****************************************
  // registered outputs
  // ****************************************
  logic [NUM_CH-1:0] en_d, flt_d;
  logic [6:0]        scale_d;
  logic              boost_d, therm_d, short_d, act_d;
  always_comb begin
    flt_d   = dis; // R15
    en_d    = (st_q == LFM_RUN) ? ~dis : '0; // R1 R5 R2
    boost_d = (st_q == LFM_RUN); // R8
    therm_d = (st_q == LFM_COOL);
    short_d = (st_q == LFM_LOCKED);
    act_d   = (st_q == LFM_RUN) || (st_q == LFM_COOL); // R14
    case (step_q)
      2'h0:    scale_d = `LFM_SCALE_FULL;
      2'h1:    scale_d = `LFM_SCALE_STEP1; // R2
      2'h2:    scale_d = `LFM_SCALE_STEP2;
      default: scale_d = `LFM_SCALE_STEP3;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_sink_channel_en <= '0;
      channel_fault       <= '0;
      boost_run           <= 1'b0;
      current_scale       <= `LFM_SCALE_FULL;
      thermal_shutdown    <= 1'b0;
      short_shutdown      <= 1'b0;
      active              <= 1'b0;
    end else begin
      led_sink_channel_en <= en_d;
      channel_fault       <= flt_d;
      boost_run           <= boost_d;
      current_scale       <= scale_d;
      thermal_shutdown    <= therm_d;
      short_shutdown      <= short_d;
      active              <= act_d;
    end
  end
endmodule // lfm_fault_manager

/* File: bench/lfm_led_model.sv */
// behavioural led strings and boost stage facing the fault manager
`timescale 1ns/10ps
module lfm_led_model (
  // device drive and bench fault setup
  input  wire logic [5:0] en,
  input  wire logic [5:0] shorted,
  input  wire logic [5:0] open_ch,
  input  wire logic [5:0] dim_ch,
  input  wire logic [5:0] zener_ch,
  // comparator outputs
  output logic [5:0]      sink_high,
  output logic [5:0]      low_cur,
  output logic            ovl
);
  // a zener-bypassed string keeps its current but lifts the sinks of the others
  assign sink_high = (shorted | ({6{|(zener_ch & en)}} & ~zener_ch)) & en;
  assign low_cur   = (open_ch | dim_ch) & en;
  assign ovl       = |(open_ch & en);
endmodule // lfm_led_model

/* File: bench/lfm_fault_manager_chk.sv */
// port assertions for the led channel fault manager
`timescale 1ns/10ps
module lfm_fault_manager_chk #(
  parameter int NUM_CH       = 6,
  parameter int SHORT_CYCLES = 200
) (
  // clock, reset and inputs
  input wire logic              clk, rstn, enable, temp_upper_trip,
  input wire logic              ovp_node_low, boost_switch_node_short,
  // outputs
  input wire logic [NUM_CH-1:0] led_sink_channel_en, channel_fault,
  input wire logic              boost_run, thermal_shutdown, short_shutdown, active,
  input wire logic [6:0]        current_scale
);
  logic [31:0] up_q, up_d;
  always_comb up_d = (up_q < SHORT_CYCLES + 8) ? up_q + 1 : up_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) up_q <= '0;
    else up_q <= up_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_fault_en_off: assert property (((channel_fault & $past(channel_fault))
    & led_sink_channel_en) == '0) else $error("faulted channel still enabled");
  a_fault_hold: assert property ((enable && $past(enable) && $past(enable, 2)
    && $past(enable, 3)) |-> ((channel_fault & $past(channel_fault)) == $past(channel_fault)))
    else $error("fault latch dropped");
  a_cool_dark: assert property (thermal_shutdown && $past(thermal_shutdown) |->
    led_sink_channel_en == '0 && !boost_run) else $error("channels on while cooling");
  a_cool_active: assert property (thermal_shutdown |-> active)
    else $error("inactive while cooling");
  a_trip_cool: assert property ($rose(temp_upper_trip) && active && enable
    && !short_shutdown |-> ##[1:6] (thermal_shutdown || short_shutdown))
    else $error("upper trip not obeyed");
  a_scale_set: assert property (current_scale inside {7'h64, 7'h4c, 7'h32, 7'h19})
    else $error("bad current scale");
  a_lock_dark: assert property (short_shutdown && $past(short_shutdown) |->
    led_sink_channel_en == '0 && !boost_run && !active) else $error("lock not dark");
  a_lock_hold: assert property (short_shutdown |=> short_shutdown)
    else $error("lock released");
  a_lock_armed: assert property (short_shutdown |-> up_q >= SHORT_CYCLES)
    else $error("lock before arming");
  a_lock_rise: assert property ((ovp_node_low || boost_switch_node_short) && active
    && up_q >= SHORT_CYCLES + 8 |-> ##[1:6] short_shutdown) else $error("short missed");
endmodule // lfm_fault_manager_chk

/* File: bench/tb.sv */
// self-checking bench for the led channel fault manager
`timescale 1ns/10ps
module tb;
  logic       clk, rstn, enable, pwm, t_low, t_up, t_cool, ovp_low, sw_short, ovl;
  logic       boost_run, th_sd, sh_sd, active;
  logic [5:0] shorted, open_ch, dim_ch, zener_ch, sink_high, low_cur, en, fault;
  logic [6:0] scale;
  int         err_count, n_tests, cyc;
  lfm_fault_manager #(.SHORT_CYCLES(200), .FAST_CYCLES(10)) dut_u (
    .clk(clk), .rstn(rstn), .enable(enable), .pwm_cycle(pwm),
    .sink_above_limit(sink_high), .below_target(low_cur), .temp_lower_trip(t_low),
    .temp_upper_trip(t_up), .temp_cooled(t_cool), .output_overvoltage_limit(ovl),
    .ovp_node_low(ovp_low), .boost_switch_node_short(sw_short),
    .led_sink_channel_en(en), .channel_fault(fault), .boost_run(boost_run),
    .current_scale(scale), .thermal_shutdown(th_sd), .short_shutdown(sh_sd),
    .active(active));
  lfm_led_model model_u (.en(en), .shorted(shorted), .open_ch(open_ch),
    .dim_ch(dim_ch), .zener_ch(zener_ch), .sink_high(sink_high), .low_cur(low_cur),
    .ovl(ovl));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      pwm = 1'b1;
      wait_n(3);
      pwm = 1'b0;
      wait_n(3);
    end
  endtask
  task automatic restart();
    enable = 1'b0;
    wait_n(8);
    enable = 1'b1;
    wait_n(8);
  endtask
  task automatic close_out();
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_start();
    ovp_low = 1'b1;
    wait_n(4);
    ovp_low = 1'b0;
    wait_n(4);
    chk(sh_sd, 0);
    chk(active, 1);
    chk(boost_run, 1);
    chk(scale, 8'h64);
    pulse(8);
    chk(en, 8'h3f);
  endtask
  task automatic t_sink();
    shorted = 6'h04;
    pulse(5);
    chk(en, 8'h3f);
    pulse(1);
    wait_n(6);
    chk(en, 8'h3b);
    chk(fault, 8'h04);
    shorted = 6'h00;
    pulse(3);
    chk(en, 8'h3b);
    restart();
    chk(fault, 8'h00);
  endtask
  task automatic t_open();
    open_ch = 6'h10;
    pulse(6);
    wait_n(6);
    chk(en, 8'h2f);
    chk(ovl, 0);
    open_ch = 6'h00;
    restart();
    dim_ch = 6'h02;
    pulse(5);
    chk(en, 8'h3f);
    pulse(1);
    wait_n(6);
    chk(fault, 8'h02);
    dim_ch = 6'h00;
    restart();
  endtask
  task automatic t_zener();
    zener_ch = 6'h20;
    pulse(5);
    chk(en, 8'h3f);
    pulse(1);
    wait_n(6);
    chk(en, 8'h20);
    chk(fault, 8'h1f);
    zener_ch = 6'h00;
    restart();
  endtask
  task automatic t_lower();
    t_low = 1'b1;
    dim_ch = 6'h01;
    shorted = 6'h08;
    wait_n(30);
    chk(en, 8'h3f);
    wait_n(70);
    chk(fault, 8'h01);
    chk(en, 8'h3e);
    t_low = 1'b0;
    dim_ch = 6'h00;
    shorted = 6'h00;
    restart();
  endtask
  task automatic t_thermal();
    for (int i = 0; i < 2; i++) begin
      t_up = 1'b1;
      wait_n(8);
      chk(th_sd, 1);
      chk({boost_run, en}, 8'h00);
      chk(active, 1);
      t_up = 1'b0;
      t_cool = 1'b1;
      wait_n(8);
      t_cool = 1'b0;
      chk(th_sd, 0);
      chk(scale, (i == 0) ? 8'h4c : 8'h32);
    end
    restart();
  endtask
  task automatic t_short();
    sw_short = 1'b1;
    wait_n(8);
    sw_short = 1'b0;
    restart();
    chk(sh_sd, 1);
    rstn = 1'b0;
    wait_n(2);
    rstn = 1'b1;
    wait_n(220);
    chk(sh_sd, 0);
    ovp_low = 1'b1;
    wait_n(8);
    chk(sh_sd, 1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    {rstn, pwm, t_low, t_up, t_cool, ovp_low, sw_short} = '0;
    {shorted, open_ch, dim_ch, zener_ch} = '0;
    enable = 1'b1;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    wait_n(2);
    rstn = 1'b1;
    wait_n(6);
    t_start();
    t_sink();
    t_open();
    t_zener();
    t_lower();
    t_thermal();
    t_short();
    close_out();
  end
endmodule // tb
bind lfm_fault_manager lfm_fault_manager_chk #(.NUM_CH(NUM_CH), .SHORT_CYCLES(SHORT_CYCLES))
  chk_u (.clk(clk), .rstn(rstn), .enable(enable), .temp_upper_trip(temp_upper_trip),
  .ovp_node_low(ovp_node_low), .boost_switch_node_short(boost_switch_node_short),
  .led_sink_channel_en(led_sink_channel_en), .channel_fault(channel_fault),
  .boost_run(boost_run), .thermal_shutdown(thermal_shutdown),
  .short_shutdown(short_shutdown), .active(active), .current_scale(current_scale));
